// ==== rtl/uvp_top.sv ====
// Three-stage definite-time undervoltage protection with four setting groups
//
// Summary of operation
// - Start when minimum line voltage below threshold
// - Trip after start outlasts operate delay
// - Selected internal or external blocks inhibit stage
// - Self-block while maximum voltage below block limit
// - Zero block limit disables self-blocking
// - Three independent definite-time stages
// - Four setting groups, full set per stage
// - Start threshold 20 to 120 percent, 1 percent steps
// - Stage one delay 0.08 to 300 s
// - Stage two delay 0.06 to 300 s
// - Hysteresis ratio 1.001 to 1.200
// - Self-block limit 0 to 80 percent
// - Stage one release delay 0.06 to 300 s
// - Self-block exit needs 0.5 V and 1.03
// - Accept-zero option permits zero operate delay
`timescale 1ns/10ps
`default_nettype none
module uvp_top #(
  parameter int unsigned TICK_CYCLES = uvp_pkg::TICK_CYC  // Cycles per 20 ms delay step
) (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  // Measured voltages and nominal, 10 mV LSB
  input  wire logic [uvp_pkg::V_W-1:0]           u12,
  input  wire logic [uvp_pkg::V_W-1:0]           u23,
  input  wire logic [uvp_pkg::V_W-1:0]           u31,
  input  wire logic [uvp_pkg::V_W-1:0]           u_nom,
  // Block sources
  input  wire logic [uvp_pkg::N_EXT-1:0]         blk_ext,
  input  wire logic [uvp_pkg::N_BLK-uvp_pkg::N_EXT-1:0] blk_int,
  // Setting write port
  input  wire logic                              cfg_we,
  input  wire logic [1:0]                        cfg_grp,
  input  wire logic [1:0]                        cfg_stg,
  input  wire uvp_pkg::uvp_set_s                 cfg_data,
  // Active group select
  input  wire logic [1:0]                        grp_sel,
  // Stage outputs
  output logic      [uvp_pkg::N_STG-1:0]         stg_start,
  output logic      [uvp_pkg::N_STG-1:0]         stg_trip,
  output logic      [uvp_pkg::N_STG-1:0]         stg_self_blk,
  // Status
  output logic      [1:0]                        active_grp,
  output logic      [uvp_pkg::V_W-1:0]           min_line_voltage,
  output logic      [uvp_pkg::V_W-1:0]           max_line_voltage
);
  import uvp_pkg::*;

  // Whole module state
  typedef struct packed {
    logic [TICK_W-1:0]                  tick_cnt;  // Delay step divider
    logic                               tick;      // One-cycle step enable
    logic                               live;      // Measurements settled
    logic [1:0]                         grp;       // Active group
    uvp_set_s [N_GRP-1:0][N_STG-1:0]    sets;      // Stored settings
    uvp_stg_s [N_STG-1:0]               stg;       // Stage states
    logic [N_STG-1:0]                   start;     // Start outputs
    logic [N_STG-1:0]                   trip;      // Trip outputs
  } uvp_top_s;

  uvp_top_s st_r;    // Registered state
  uvp_top_s st_nxt;  // Next state

  logic [V_W-1:0]   vmin;      // Smallest line voltage
  logic [V_W-1:0]   vmax;      // Largest line voltage
  logic [N_EXT-1:0] ext_sync;  // Settled external blocks

  // Voltage reduction and pin synchroniser
  uvp_meas u_meas (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .u12              (u12),
    .u23              (u23),
    .u31              (u31),
    .blk_pin          (blk_ext),
    .min_line_voltage (vmin),
    .max_line_voltage (vmax),
    .blk_sync         (ext_sync)
  );

  // Widened product
  function automatic logic [M_W-1:0] mul(input logic [M_W-1:0] a, input logic [M_W-1:0] b);
    mul = M_W'(a * b);
  endfunction

  // Clamp a delay code into its range
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [DLY_W-1:0] v,
                                                 input logic [DLY_W-1:0] lo);
    if (v < lo) begin
      clamp_dly = lo;
    end else if (v > DLY_MAX_TK) begin
      clamp_dly = DLY_MAX_TK;
    end else begin
      clamp_dly = v;
    end
  endfunction

  // Per-stage working values
  uvp_set_s         cs;       // Active settings
  logic [6:0]       spct;     // Clamped start percent
  logic [7:0]       hyst;     // Clamped hysteresis
  logic [6:0]       bpct;     // Clamped block percent
  logic [DLY_W-1:0] odly;     // Effective operate delay
  logic [DLY_W-1:0] omin;     // Least operate delay
  logic [DLY_W-1:0] rdly;     // Effective release delay
  logic [M_W-1:0]   thr;      // Start threshold, scaled by 100
  logic [M_W-1:0]   blim;     // Block limit, scaled by 100
  logic             under;    // Minimum below start
  logic             recov;    // Minimum above reset level
  logic             blk_in;   // Maximum below block limit
  logic             blk_out;  // Maximum clear of block margin
  logic             inhibit;  // Stage held off
  logic [N_BLK-1:0] blk_vec;  // All block sources

  // Next-state logic
  always_comb begin
    st_nxt   = st_r;
    cs       = DEF_SET;
    spct     = START_MIN;
    hyst     = HYST_MIN;
    bpct     = DEF_BLK;
    odly     = DEF_DLY;
    omin     = OP1_MIN_TK;
    rdly     = '0;
    thr      = '0;
    blim     = '0;
    under    = 1'b0;
    recov    = 1'b0;
    blk_in   = 1'b0;
    blk_out  = 1'b0;
    inhibit  = 1'b0;
    blk_vec  = {blk_int, ext_sync};
    // Reduced voltages read zero until one edge after reset; no false start
    st_nxt.live = 1'b1;
    // Delay step divider
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt >= TICK_W'(TICK_CYCLES - 1)) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end
    // Setting storage and group select
    if (cfg_we && (cfg_stg < 2'(N_STG))) begin
      st_nxt.sets[cfg_grp][cfg_stg] = cfg_data;
    end
    st_nxt.grp = grp_sel;
    // Each stage runs on its own settings
    for (int i = 0; i < N_STG; i++) begin
      cs   = st_r.sets[st_r.grp][i];
      spct = (cs.start_pct < START_MIN) ? START_MIN :
             (cs.start_pct > START_MAX) ? START_MAX : cs.start_pct;
      hyst = (cs.hyst < HYST_MIN) ? HYST_MIN :
             (cs.hyst > HYST_MAX) ? HYST_MAX : cs.hyst;
      bpct = (cs.blk_pct > BLK_MAX) ? BLK_MAX : cs.blk_pct;
      // Least operate delay per stage, zero if accepted
      omin = (i == 0) ? OP1_MIN_TK : OP2_MIN_TK;
      if (cs.accept_zero) begin
        omin = '0;
      end
      odly = clamp_dly(cs.op_dly, omin);
      rdly = (i == 0) ? clamp_dly(cs.rel_dly, REL_MIN_TK) : '0;
      // Threshold comparisons scaled by 100; hysteresis by a further 1000, exit ratio by a further 100
      thr   = mul(M_W'(u_nom), M_W'(spct));
      blim  = mul(M_W'(u_nom), M_W'(bpct));
      under = st_r.live && (mul(M_W'(vmin), PCT_DEN) < thr);
      recov = mul(mul(M_W'(vmin), PCT_DEN), HYST_DEN) >
              mul(thr, HYST_DEN + M_W'(hyst));
      blk_in  = (bpct != '0) && (mul(M_W'(vmax), PCT_DEN) < blim);
      blk_out = (mul(M_W'(vmax), PCT_DEN) > blim + mul(BLK_MARG, PCT_DEN)) &&
                (mul(mul(M_W'(vmax), PCT_DEN), PCT_DEN) > mul(blim, BLK_RATIO));
      // Self-block flag with exit margin
      if (bpct == '0) begin
        st_nxt.stg[i].sblk = 1'b0;
      end else if (blk_in) begin
        st_nxt.stg[i].sblk = 1'b1;
      end else if (blk_out) begin
        st_nxt.stg[i].sblk = 1'b0;
      end
      inhibit = |(blk_vec & cs.blk_mask) || st_r.stg[i].sblk || blk_in;
      // Release hold counts down on steps
      if (st_r.stg[i].rel != '0 && st_r.tick) begin
        st_nxt.stg[i].rel = st_r.stg[i].rel - 1'b1;
      end
      if (inhibit) begin
        // Held off: no start, no timing, no trip
        st_nxt.stg[i].st  = STG_IDLE;
        st_nxt.stg[i].tmr = '0;
        st_nxt.stg[i].rel = '0;
      end else begin
        unique case (st_r.stg[i].st)
          STG_IDLE: begin
            if (under) begin
              st_nxt.stg[i].st  = STG_START;
              st_nxt.stg[i].tmr = '0;
            end
          end
          STG_START: begin
            if (recov) begin
              st_nxt.stg[i].st  = STG_IDLE;
              st_nxt.stg[i].tmr = '0;
            end else if (st_r.stg[i].tmr >= odly) begin
              st_nxt.stg[i].st  = STG_TRIP;
            end else if (st_r.tick) begin
              st_nxt.stg[i].tmr = st_r.stg[i].tmr + 1'b1;
            end
          end
          STG_TRIP: begin
            if (recov) begin
              st_nxt.stg[i].st  = STG_IDLE;
              st_nxt.stg[i].tmr = '0;
              st_nxt.stg[i].rel = rdly;
            end
          end
          default: begin
            // Illegal code recovers to idle
            st_nxt.stg[i].st  = STG_IDLE;
            st_nxt.stg[i].tmr = '0;
          end
        endcase
      end
      // Output levels from the next state
      st_nxt.start[i] = (st_nxt.stg[i].st != STG_IDLE);
      st_nxt.trip[i]  = (st_nxt.stg[i].st == STG_TRIP) ||
                        (st_nxt.stg[i].rel != '0);
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.tick_cnt <= '0;
      st_r.tick     <= 1'b0;
      st_r.live     <= 1'b0;
      st_r.grp      <= '0;
      st_r.sets     <= {(N_GRP * N_STG){DEF_SET}};
      st_r.stg      <= '0;
      st_r.start    <= '0;
      st_r.trip     <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  always_comb begin
    for (int i = 0; i < N_STG; i++) begin
      stg_self_blk[i] = st_r.stg[i].sblk;
    end
  end
  assign stg_start        = st_r.start;
  assign stg_trip         = st_r.trip;
  assign active_grp       = st_r.grp;
  assign min_line_voltage = vmin;
  assign max_line_voltage = vmax;
endmodule
`default_nettype wire

// ==== rtl/uvp_pkg.sv ====
// Package for the undervoltage protection stages: constants, settings and state types
package uvp_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ      = 50_000_000;               // System clock rate
  localparam int unsigned TICK_MS     = 20;                       // Delay resolution, 0.02 s
  localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;  // Cycles per delay step
  localparam int unsigned TICK_W      = 20;                       // Divider counter width
  // Structure sizes
  localparam int unsigned N_STG       = 3;                        // Independent stages
  localparam int unsigned N_GRP       = 4;                        // Setting groups
  localparam int unsigned N_BLK       = 8;                        // Block sources per stage
  localparam int unsigned N_EXT       = 4;                        // External block pins
  localparam int unsigned V_W         = 16;                       // Voltage width, 10 mV LSB
  localparam int unsigned DLY_W       = 14;                       // Delay code width, ticks
  localparam int unsigned M_W         = 48;                       // Product width
  // Setting ranges
  localparam logic [6:0]  START_MIN   = 7'h14;                    // 20 % of nominal
  localparam logic [6:0]  START_MAX   = 7'h78;                    // 120 % of nominal
  localparam logic [7:0]  HYST_MIN    = 8'h01;                    // Ratio 1.001
  localparam logic [7:0]  HYST_MAX    = 8'hC8;                    // Ratio 1.200
  localparam logic [6:0]  BLK_MAX     = 7'h50;                    // 80 % of nominal
  localparam int unsigned DLY_MAX_MS  = 300_000;                  // 300.00 s longest delay
  localparam int unsigned OP1_MIN_MS  = 80;                       // Stage 1 least operate time
  localparam int unsigned OP2_MIN_MS  = 60;                       // Stage 2/3 least operate time
  localparam int unsigned REL_MIN_MS  = 60;                       // Least release delay
  localparam logic [DLY_W-1:0] DLY_MAX_TK = DLY_W'(DLY_MAX_MS / TICK_MS);
  localparam logic [DLY_W-1:0] OP1_MIN_TK = DLY_W'((OP1_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [DLY_W-1:0] OP2_MIN_TK = DLY_W'((OP2_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [DLY_W-1:0] REL_MIN_TK = DLY_W'((REL_MIN_MS + TICK_MS - 1) / TICK_MS);
  // Arithmetic scales
  localparam logic [M_W-1:0] PCT_DEN   = M_W'(100);               // Percent denominator
  localparam logic [M_W-1:0] HYST_DEN  = M_W'(1000);              // Hysteresis denominator
  localparam logic [M_W-1:0] BLK_RATIO = M_W'(103);               // Self-block exit ratio 1.03
  localparam logic [M_W-1:0] BLK_MARG  = M_W'(50);                // 0.5 V in 10 mV steps
  // Reset values of every stored setting
  localparam logic [6:0]       DEF_START = 7'h46;                 // 70 %
  localparam logic [7:0]       DEF_HYST  = 8'h1E;                 // Ratio 1.030
  localparam logic [6:0]       DEF_BLK   = 7'h00;                 // Self-block off
  localparam logic [DLY_W-1:0] DEF_DLY   = 14'h0019;              // 0.50 s
  localparam logic [N_BLK-1:0] DEF_MASK  = 8'h00;                 // No block source
  // One stage's settings within a group
  typedef struct packed {
    logic             accept_zero;  // Allow zero operate delay
    logic [N_BLK-1:0] blk_mask;     // Selected block sources
    logic [DLY_W-1:0] rel_dly;      // Release delay, ticks
    logic [DLY_W-1:0] op_dly;       // Operate delay, ticks
    logic [6:0]       blk_pct;      // Self-block limit, % nominal
    logic [7:0]       hyst;         // Hysteresis, 0.1 % steps
    logic [6:0]       start_pct;    // Start threshold, % nominal
  } uvp_set_s;
  localparam uvp_set_s DEF_SET = '{1'b0, DEF_MASK, DEF_DLY, DEF_DLY, DEF_BLK, DEF_HYST,
                                   DEF_START};
  // Stage sequence states
  typedef enum logic [1:0] {
    STG_IDLE  = 2'b00,
    STG_START = 2'b01,
    STG_TRIP  = 2'b10
  } uvp_stg_e;
  // One stage's dynamic state
  typedef struct packed {
    uvp_stg_e         st;    // Sequence state
    logic             sblk;  // Self-blocked
    logic [DLY_W-1:0] tmr;   // Operate timer
    logic [DLY_W-1:0] rel;   // Release hold counter
  } uvp_stg_s;
endpackage

// ==== rtl/uvp_meas.sv ====
// Min/max reduction of the line voltages and synchroniser for the block pins
`timescale 1ns/10ps
`default_nettype none
module uvp_meas (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Line-to-line voltages
  input  wire logic [uvp_pkg::V_W-1:0]       u12,
  input  wire logic [uvp_pkg::V_W-1:0]       u23,
  input  wire logic [uvp_pkg::V_W-1:0]       u31,
  // External block pins
  input  wire logic [uvp_pkg::N_EXT-1:0]     blk_pin,
  // Reduced results
  output logic      [uvp_pkg::V_W-1:0]       min_line_voltage,
  output logic      [uvp_pkg::V_W-1:0]       max_line_voltage,
  output logic      [uvp_pkg::N_EXT-1:0]     blk_sync
);
  import uvp_pkg::*;

  // Whole module state
  typedef struct packed {
    logic [2:0][N_EXT-1:0] sync;  // Three-stage pin chain
    logic [N_EXT-1:0]      blk;   // Accepted pin level
    logic [V_W-1:0]        vmin;  // Smallest line voltage
    logic [V_W-1:0]        vmax;  // Largest line voltage
  } uvp_meas_s;

  uvp_meas_s st_r;   // Registered state
  uvp_meas_s st_nxt; // Next state

  // Smaller of two voltages
  function automatic logic [V_W-1:0] vmin2(input logic [V_W-1:0] a, input logic [V_W-1:0] b);
    vmin2 = (a < b) ? a : b;
  endfunction

  // Larger of two voltages
  function automatic logic [V_W-1:0] vmax2(input logic [V_W-1:0] a, input logic [V_W-1:0] b);
    vmax2 = (a > b) ? a : b;
  endfunction

  // Next-state logic
  always_comb begin
    st_nxt         = st_r;
    st_nxt.sync[0] = blk_pin;                                    // First flop sees the pin
    st_nxt.sync[1] = st_r.sync[0];
    st_nxt.sync[2] = st_r.sync[1];
    if (st_r.sync[1] == st_r.sync[2]) begin
      st_nxt.blk = st_r.sync[2];                                 // Change counts once settled
    end
    st_nxt.vmin    = vmin2(vmin2(u12, u23), u31);
    st_nxt.vmax    = vmax2(vmax2(u12, u23), u31);
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign min_line_voltage = st_r.vmin;
  assign max_line_voltage = st_r.vmax;
  assign blk_sync         = st_r.blk;
endmodule
`default_nettype wire

// ==== tb/uvp_top_monitor.sv ====
// Concurrent checks on the undervoltage stage ports
`timescale 1ns/10ps
`default_nettype none
module uvp_mon import uvp_pkg::*; #(
  parameter int unsigned TICK_CYCLES = 4  // Cycles per delay step
) (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  // Measurement and blocks
  input wire logic [V_W-1:0]       u12,
  input wire logic [V_W-1:0]       u23,
  input wire logic [V_W-1:0]       u31,
  input wire logic [V_W-1:0]       u_nom,
  input wire logic [N_EXT-1:0]     blk_ext,
  input wire logic [N_BLK-N_EXT-1:0] blk_int,
  // Settings
  input wire logic                 cfg_we,
  input wire logic [1:0]           cfg_grp,
  input wire logic [1:0]           cfg_stg,
  input wire uvp_set_s             cfg_data,
  input wire logic [1:0]           grp_sel,
  // Outputs
  input wire logic [N_STG-1:0]     stg_start,
  input wire logic [N_STG-1:0]     stg_trip,
  input wire logic [N_STG-1:0]     stg_self_blk,
  input wire logic [1:0]           active_grp,
  input wire logic [V_W-1:0]       min_line_voltage,
  input wire logic [V_W-1:0]       max_line_voltage
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [V_W-1:0] m01;      // Lower of first pair
  logic [V_W-1:0] x01;      // Higher of first pair
  logic [V_W-1:0] vmin_in;  // Lowest input voltage
  logic [V_W-1:0] vmax_in;  // Highest input voltage
  logic           hi_min;   // Minimum above any reset level
  logic           hi_max;   // Maximum clear of any block exit level
  assign m01     = (u12 < u23) ? u12 : u23;
  assign x01     = (u12 > u23) ? u12 : u23;
  assign vmin_in = (m01 < u31) ? m01 : u31;
  assign vmax_in = (x01 > u31) ? x01 : u31;
  assign hi_min  = ({16'h0000, min_line_voltage} * 32'h64) > ({16'h0000, u_nom} * 32'h90);
  assign hi_max  = ({16'h0000, max_line_voltage} * 32'h64) >
                   ({16'h0000, u_nom} * 32'h53 + 32'h1388);
  // Edge patterns of the stage sequence
  sequence s_start_rise;
    !stg_start[1] ##1 stg_start[1];
  endsequence
  sequence s_trip_rise;
    !stg_trip[2] ##1 stg_trip[2];
  endsequence
  AST_MIN_REDUCE: assert property (!$past(sys_rst) |-> min_line_voltage == $past(vmin_in))
    else $error("minimum line voltage wrong");
  AST_MAX_REDUCE: assert property (!$past(sys_rst) |-> max_line_voltage == $past(vmax_in))
    else $error("maximum line voltage wrong");
  AST_GROUP_TAKE: assert property (!$past(sys_rst) |-> active_grp == $past(grp_sel))
    else $error("active group not taken");
  AST_HIGH_NO_START: assert property (hi_min |=> stg_start == 3'h0)
    else $error("start above highest threshold");
  AST_HIGH_NO_SBLK: assert property (hi_max |=> stg_self_blk == 3'h0)
    else $error("self block above exit level");
  AST_SBLK_INHIBIT: assert property (stg_self_blk[0] && $past(stg_self_blk[0]) |-> !stg_start[0])
    else $error("start while self blocked");
  AST_TRIP_IN_START: assert property (stg_trip[1] |-> stg_start[1])
    else $error("trip without start");
  AST_TRIP_WAITS: assert property (s_start_rise |-> !stg_trip[1])
    else $error("trip together with start");
  AST_TRIP_FROM_START: assert property (s_trip_rise |-> stg_start[2])
    else $error("trip rose outside start");
endmodule
`default_nettype wire

// ==== tb/uvp_front.sv ====
// Behavioural front end: healthy line voltages with u23 dipped on command
`timescale 1ns/10ps
`default_nettype none
module uvp_front (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Commanded levels
  input  wire logic [uvp_pkg::V_W-1:0] lvl,
  input  wire logic [uvp_pkg::V_W-1:0] dip,
  // Line voltages
  output logic      [uvp_pkg::V_W-1:0] u12,
  output logic      [uvp_pkg::V_W-1:0] u23,
  output logic      [uvp_pkg::V_W-1:0] u31
);
  // Measurement refresh, one cycle behind the command
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      u12 <= lvl;
      u23 <= lvl;
      u31 <= lvl;
    end else begin
      u12 <= lvl;
      u23 <= dip;
      u31 <= lvl;
    end
  end
endmodule
`default_nettype wire

// ==== tb/uvp_top_tb_top.sv ====
// Testbench top for the undervoltage protection stages
`timescale 1ns/10ps
`default_nettype none
module uvp_top_tb_top;
  import uvp_pkg::*;
  localparam int unsigned TICK_CYCLES = 4;  // Short delay step
  logic sys_clk = 1'b0;  // System clock
  logic sys_rst = 1'b1;  // Reset
  logic [V_W-1:0] lvl, dip, u12, u23, u31, u_nom, min_v, max_v;
  logic [N_EXT-1:0] blk_ext;  // External blocks
  logic [3:0] blk_int;        // Internal blocks
  logic cfg_we;               // Write strobe
  logic [1:0] cfg_grp, cfg_stg, grp_sel, active_grp;
  uvp_set_s cfg_data;         // Setting word
  logic [N_STG-1:0] stg_start, stg_trip, stg_self_blk;
  int n_fail = 0;             // Mismatches
  int samples_checked = 0;    // Comparisons
  int cycles = 0;             // Watchdog
  always #10 sys_clk = ~sys_clk;
  uvp_front uvp_front_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .lvl(lvl), .dip(dip),
    .u12(u12), .u23(u23), .u31(u31));
  uvp_top #(.TICK_CYCLES(TICK_CYCLES)) uvp_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .u12(u12), .u23(u23), .u31(u31), .u_nom(u_nom), .blk_ext(blk_ext), .blk_int(blk_int),
    .cfg_we(cfg_we), .cfg_grp(cfg_grp), .cfg_stg(cfg_stg), .cfg_data(cfg_data),
    .grp_sel(grp_sel), .stg_start(stg_start), .stg_trip(stg_trip),
    .stg_self_blk(stg_self_blk), .active_grp(active_grp), .min_line_voltage(min_v),
    .max_line_voltage(max_v));
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare a per-stage vector
  task automatic chk_bits(input string what, input logic [2:0] exp, input logic [2:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Compare a voltage word
  task automatic chk_volt(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Stage setting with short delays
  function automatic uvp_set_s mk(input logic [7:0] m, input logic [6:0] b, input logic [6:0] s);
    mk = '{1'b0, m, 14'h0005, 14'h0005, b, 8'h1E, s};
  endfunction
  // One setting write
  task automatic wr(input logic [1:0] g, input logic [1:0] s, input uvp_set_s d);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_grp <= g;
    cfg_stg <= s;
    cfg_data <= d;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
  endtask
  // Let n edges land
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Command voltages, then wait past the pipeline
  task automatic volts(input logic [15:0] a, input logic [15:0] b);
    @(posedge sys_clk);
    lvl <= a;
    dip <= b;
    step(5);
  endtask
  // Bounded wait for a trip pattern
  task automatic wait_trip(input logic [2:0] e);
    for (int n = 0; n < 60 && stg_trip !== e; n++)
      step(1);
  endtask
  // Start, trip, recovery and release hold
  task automatic t_start();
    for (int s = 0; s < 3; s++)
      wr(2'h0, 2'(s), mk(8'h00, 7'h00, 7'h46));
    volts(16'h2710, 16'h1770);
    chk_bits("start on dip", 3'h7, stg_start);
    chk_volt("min voltage", 16'h1770, min_v);
    chk_volt("max voltage", 16'h2710, max_v);
    step(12);
    chk_bits("trip early", 3'h0, stg_trip);
    wait_trip(3'h7);
    chk_bits("trip", 3'h7, stg_trip);
    volts(16'h2710, 16'h2710);
    chk_bits("start recovered", 3'h0, stg_start);
    chk_bits("trip held", 3'h1, stg_trip);
    wait_trip(3'h0);
    chk_bits("trip released", 3'h0, stg_trip);
  endtask
  // Internal and external blocks per stage
  task automatic t_block();
    wr(2'h0, 2'h1, mk(8'h10, 7'h00, 7'h46));
    wr(2'h0, 2'h2, mk(8'h01, 7'h00, 7'h46));
    blk_int <= 4'h1;
    volts(16'h2710, 16'h1770);
    chk_bits("internal block", 3'h5, stg_start);
    @(posedge sys_clk);
    blk_ext <= 4'h1;
    step(8);
    chk_bits("external block", 3'h1, stg_start);
    @(posedge sys_clk);
    blk_int <= 4'h0;
    blk_ext <= 4'h0;
    volts(16'h2710, 16'h2710);
    wait_trip(3'h0);
  endtask
  // Self block entry, zero limit, exit margin
  task automatic t_selfblk();
    wr(2'h0, 2'h0, mk(8'h00, 7'h32, 7'h46));
    wr(2'h0, 2'h1, mk(8'h00, 7'h00, 7'h46));
    wr(2'h0, 2'h2, mk(8'h00, 7'h00, 7'h46));
    volts(16'h0FA0, 16'h0BB8);
    chk_bits("self block set", 3'h1, stg_self_blk);
    chk_bits("start zero limit", 3'h6, stg_start);
    volts(16'h13EC, 16'h0BB8);
    chk_bits("self block margin", 3'h1, stg_self_blk);
    volts(16'h1450, 16'h0BB8);
    chk_bits("self block exit", 3'h0, stg_self_blk);
    chk_bits("start after exit", 3'h7, stg_start);
    wr(2'h0, 2'h0, mk(8'h00, 7'h00, 7'h46));
    volts(16'h2710, 16'h2710);
    wait_trip(3'h0);
  endtask
  // Zero operate delay accepted on the third stage
  task automatic t_zero();
    wr(2'h0, 2'h2, '{1'b1, 8'h00, 14'h0005, 14'h0000, 7'h00, 8'h1E, 7'h46});
    volts(16'h2710, 16'h1770);
    chk_bits("zero delay trip", 3'h4, stg_trip);
    volts(16'h2710, 16'h2710);
    wait_trip(3'h0);
  endtask
  // Group switch with highest start setting
  task automatic t_group();
    for (int s = 0; s < 3; s++)
      wr(2'h2, 2'(s), mk(8'h00, 7'h00, 7'h78));
    grp_sel <= 2'h2;
    volts(16'h2AF8, 16'h2AF8);
    chk_bits("group", 3'h2, {1'b0, active_grp});
    chk_bits("start at 120", 3'h7, stg_start);
    @(posedge sys_clk);
    grp_sel <= 2'h0;
    step(5);
    chk_bits("start group 0", 3'h0, stg_start);
    volts(16'h3A98, 16'h3A98);
    chk_bits("start far above", 3'h0, stg_start);
  endtask
  // Watchdog
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    {lvl, dip, u_nom} = {3{16'h2710}};
    {blk_ext, blk_int, cfg_we, cfg_grp, cfg_stg, grp_sel} = '0;
    cfg_data = '0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    step(1);
    chk_bits("idle first edge", 3'h0, stg_start | stg_trip | stg_self_blk);
    step(1);
    chk_bits("idle after reset", 3'h0, stg_start | stg_trip | stg_self_blk);
    t_start();
    t_block();
    t_selfblk();
    t_zero();
    t_group();
    complete_run();
  end
endmodule
bind uvp_top uvp_mon #(.TICK_CYCLES(TICK_CYCLES)) uvp_mon_i (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .u12(u12), .u23(u23), .u31(u31), .u_nom(u_nom), .blk_ext(blk_ext),
  .blk_int(blk_int), .cfg_we(cfg_we), .cfg_grp(cfg_grp), .cfg_stg(cfg_stg),
  .cfg_data(cfg_data), .grp_sel(grp_sel), .stg_start(stg_start), .stg_trip(stg_trip),
  .stg_self_blk(stg_self_blk), .active_grp(active_grp),
  .min_line_voltage(min_line_voltage), .max_line_voltage(max_line_voltage));
`default_nettype wire
